/* clf_pkg.sv */
// Shared constants for the current-limit lock fault handler
package clf_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 100;
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ACTION_MSB    = 17;
  localparam int         ACTION_LSB    = 15;
  localparam int         FILTER_MSB    = 14;
  localparam int         FILTER_LSB    = 11;
  localparam logic [2:0] ACTION_RESET  = 3'h0;
  localparam logic [3:0] FILTER_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Action codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ACT_LATCH_TRI   = 3'h0;
  localparam logic [2:0] ACT_LATCH_LOW   = 3'h1;
  localparam logic [2:0] ACT_LATCH_HIGH  = 3'h2;
  localparam logic [2:0] ACT_RETRY_TRI   = 3'h3;
  localparam logic [2:0] ACT_RETRY_LOW   = 3'h4;
  localparam logic [2:0] ACT_RETRY_HIGH  = 3'h5;
  localparam logic [2:0] ACT_REPORT      = 3'h6;
  localparam logic [2:0] ACT_DISABLED    = 3'h7;

  // ----------------------------------------------------------------
  // Filter times in 0.1 ms ticks, code 0h to Fh (Fh repeats Eh)
  // ----------------------------------------------------------------
  localparam logic [12:0] FILTER_TICKS [16] = '{
    13'h0000, 13'h0001, 13'h0002, 13'h0005, 13'h000A, 13'h0019, 13'h0032, 13'h004B,
    13'h0064, 13'h00FA, 13'h01F4, 13'h02EE, 13'h03E8, 13'h07D0, 13'h1388, 13'h1388};

  typedef enum logic [1:0] {ST_RUN, ST_LATCH, ST_RETRY, ST_REPORT} clf_state_type;

endpackage

/* clf_tick_div.sv */
// Restartable divider giving one-cycle 0.1 ms enable pulses
`timescale 1ns/1ns
module clf_tick_div #(
  parameter int CYCLES = clf_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic restart,
  output logic      tick
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign tick = (count == W'(CYCLES - 1)) && !restart;

  always_comb
  begin
    if (restart || tick)
      next_count = '0;
    else
      next_count = count + W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      count <= '0;
    else
      count <= next_count;
  end

endmodule // clf_tick_div

/* clf_lock_fault.sv */
// Current-limit lock detection filter and fault reaction state machine
// What this block does
// - 3-bit action field, bits 17-15, reset 0h, selects lock reaction.
// - Code 0h: latch fault, assert fault pin, tristate gate driver.
// - Code 1h: latch fault, assert fault pin, brake on low sides.
// - Code 2h: latch fault, assert fault pin, brake on high sides.
// - Code 3h: tristate, fault pin, auto clear after wait, latch past limit.
// - Code 4h: low-side brake, fault pin, auto clear up to retry limit.
// - Code 5h: high-side brake, fault pin, auto clear, latch past limit.
// - Code 6h: report only on fault pin, gate driver untouched.
// - Code 7h: detection disabled, no fault and no gate action.
// - 4-bit filter field, bits 14-11, codes select none up to 500 ms.
`timescale 1ns/1ns
module clf_lock_fault #(
  parameter int TICK_CYCLES = clf_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [2:0]  lockAction,
  input  wire logic [3:0]  lockCurrentLimitFilterTime,
  input  wire logic [15:0] faultRetryWait,
  input  wire logic [3:0]  retryCountLimit,
  input  wire logic        overLimit,
  input  wire logic        faultClear,
  output logic             faultIndicatorN,
  output logic             gateTristate,
  output logic             lowSideBrake,
  output logic             highSideBrake,
  output logic             lockFault,
  output logic [3:0]       retryCount
);

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  clf_pkg::clf_state_type state;
  clf_pkg::clf_state_type next_state;
  logic                   tick;
  logic                   restartTick;

  assign restartTick = (state != next_state) || (!overLimit && state != clf_pkg::ST_RETRY);

  clf_tick_div #(.CYCLES(TICK_CYCLES)) u_div (
    .clk     (clk),
    .resetn  (resetn),
    .restart (restartTick),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  logic [12:0] filtCnt;
  logic [12:0] next_filtCnt;
  logic [12:0] filtTarget;
  logic        detect;

  assign filtTarget = clf_pkg::FILTER_TICKS[lockCurrentLimitFilterTime];
  assign detect     = overLimit && (filtCnt >= filtTarget) && state == clf_pkg::ST_RUN;

  always_comb
  begin
    if (!overLimit || state != clf_pkg::ST_RUN)
      next_filtCnt = '0;
    else if (tick && filtCnt < filtTarget)
      next_filtCnt = filtCnt + 13'h0001;
    else
      next_filtCnt = filtCnt;
  end

  // ----------------------------------------------------------------
  // Reaction state machine
  // ----------------------------------------------------------------
  logic [2:0]  actMode;
  logic [2:0]  next_actMode;
  logic [15:0] waitCnt;
  logic [15:0] next_waitCnt;
  logic [3:0]  next_retryCount;
  logic        next_faultIndicatorN;
  logic        next_gateTristate;
  logic        next_lowSideBrake;
  logic        next_highSideBrake;
  logic        next_lockFault;

  always_comb
  begin
    next_state      = state;
    next_actMode    = actMode;
    next_retryCount = retryCount;
    case (state)
      clf_pkg::ST_RUN:
      begin
        if (detect && lockAction != clf_pkg::ACT_DISABLED)
        begin
          next_actMode = lockAction;
          case (lockAction)
            clf_pkg::ACT_RETRY_TRI, clf_pkg::ACT_RETRY_LOW, clf_pkg::ACT_RETRY_HIGH:
            begin
              if (retryCount >= retryCountLimit)
                next_state = clf_pkg::ST_LATCH;
              else
              begin
                next_state      = clf_pkg::ST_RETRY;
                next_retryCount = retryCount + 4'h1;
              end
            end
            clf_pkg::ACT_REPORT:
              next_state = clf_pkg::ST_REPORT;
            default:
              next_state = clf_pkg::ST_LATCH;
          endcase
        end
      end
      clf_pkg::ST_RETRY:
      begin
        if (waitCnt >= faultRetryWait)
          next_state = clf_pkg::ST_RUN;
      end
      clf_pkg::ST_LATCH:
      begin
        if (faultClear)
        begin
          next_state      = clf_pkg::ST_RUN;
          next_retryCount = 4'h0;
        end
      end
      clf_pkg::ST_REPORT:
      begin
        if (!overLimit || lockAction == clf_pkg::ACT_DISABLED)
          next_state = clf_pkg::ST_RUN;
      end
      default:
        next_state = clf_pkg::ST_RUN;
    endcase
  end

  // Retry wait counter, apart from the state logic so the tick cannot loop back into it
  always_comb
  begin
    if (state != clf_pkg::ST_RETRY)
      next_waitCnt = '0;
    else if (tick && waitCnt < faultRetryWait)
      next_waitCnt = waitCnt + 16'h0001;
    else
      next_waitCnt = waitCnt;
  end

  // Pin levels follow the next state so they change with it
  always_comb
  begin
    next_faultIndicatorN = (next_state == clf_pkg::ST_RUN);
    next_lockFault       = (next_state == clf_pkg::ST_LATCH);
    next_gateTristate    = 1'b0;
    next_lowSideBrake    = 1'b0;
    next_highSideBrake   = 1'b0;
    if (next_state == clf_pkg::ST_LATCH || next_state == clf_pkg::ST_RETRY)
    begin
      case (next_actMode)
        clf_pkg::ACT_LATCH_TRI, clf_pkg::ACT_RETRY_TRI:
          next_gateTristate = 1'b1;
        clf_pkg::ACT_LATCH_LOW, clf_pkg::ACT_RETRY_LOW:
          next_lowSideBrake = 1'b1;
        clf_pkg::ACT_LATCH_HIGH, clf_pkg::ACT_RETRY_HIGH:
          next_highSideBrake = 1'b1;
        default:
          next_gateTristate = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state           <= clf_pkg::ST_RUN;
      actMode         <= clf_pkg::ACTION_RESET;
      filtCnt         <= '0;
      waitCnt         <= '0;
      retryCount      <= 4'h0;
      faultIndicatorN <= 1'b1;
      gateTristate    <= 1'b0;
      lowSideBrake    <= 1'b0;
      highSideBrake   <= 1'b0;
      lockFault       <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      actMode         <= next_actMode;
      filtCnt         <= next_filtCnt;
      waitCnt         <= next_waitCnt;
      retryCount      <= next_retryCount;
      faultIndicatorN <= next_faultIndicatorN;
      gateTristate    <= next_gateTristate;
      lowSideBrake    <= next_lowSideBrake;
      highSideBrake   <= next_highSideBrake;
      lockFault       <= next_lockFault;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_mode0;
    @(posedge clk) disable iff (!resetn)
    detect && lockAction == clf_pkg::ACT_LATCH_TRI |=> lockFault && gateTristate && !faultIndicatorN;
  endproperty
  a_mode0: assert property (p_mode0) else $error("code 0 did not latch tristate");

  property p_mode1;
    @(posedge clk) disable iff (!resetn)
    detect && lockAction == clf_pkg::ACT_LATCH_LOW |=> lockFault && lowSideBrake && !gateTristate;
  endproperty
  a_mode1: assert property (p_mode1) else $error("code 1 did not brake low");

  property p_mode2;
    @(posedge clk) disable iff (!resetn)
    detect && lockAction == clf_pkg::ACT_LATCH_HIGH |=> lockFault && highSideBrake && !lowSideBrake;
  endproperty
  a_mode2: assert property (p_mode2) else $error("code 2 did not brake high");

  property p_latchHolds;
    @(posedge clk) disable iff (!resetn)
    lockFault && !faultClear |=> lockFault && !faultIndicatorN;
  endproperty
  a_latchHolds: assert property (p_latchHolds) else $error("latched fault dropped");

  property p_retryEnd;
    @(posedge clk) disable iff (!resetn)
    state == clf_pkg::ST_RETRY && waitCnt >= faultRetryWait |=> faultIndicatorN && !gateTristate;
  endproperty
  a_retryEnd: assert property (p_retryEnd) else $error("retry wait did not release");

  property p_retryLow;
    @(posedge clk) disable iff (!resetn)
    detect && lockAction == clf_pkg::ACT_RETRY_LOW && retryCount < retryCountLimit
      |=> lowSideBrake && !lockFault && retryCount == $past(retryCount) + 4'h1;
  endproperty
  a_retryLow: assert property (p_retryLow) else $error("code 4 retry wrong");

  property p_retryHighLatch;
    @(posedge clk) disable iff (!resetn)
    detect && lockAction == clf_pkg::ACT_RETRY_HIGH && retryCount >= retryCountLimit
      |=> lockFault && highSideBrake;
  endproperty
  a_retryHighLatch: assert property (p_retryHighLatch) else $error("code 5 did not latch");

  property p_report;
    @(posedge clk) disable iff (!resetn)
    detect && lockAction == clf_pkg::ACT_REPORT
      |=> !faultIndicatorN && !gateTristate && !lowSideBrake && !highSideBrake;
  endproperty
  a_report: assert property (p_report) else $error("report mode touched gates");

  property p_disabled;
    @(posedge clk) disable iff (!resetn)
    state == clf_pkg::ST_RUN && lockAction == clf_pkg::ACT_DISABLED |=> faultIndicatorN;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled mode raised fault");

  property p_noFilter;
    @(posedge clk) disable iff (!resetn)
    state == clf_pkg::ST_RUN && overLimit && lockCurrentLimitFilterTime == 4'h0 |-> detect;
  endproperty
  a_noFilter: assert property (p_noFilter) else $error("no-filter code delayed");

  property p_needsPersist;
    @(posedge clk) disable iff (!resetn)
    !overLimit |-> !detect ##1 filtCnt == 13'h0000;
  endproperty
  a_needsPersist: assert property (p_needsPersist) else $error("filter not restarted");

  c_latch:  cover property (@(posedge clk) disable iff (!resetn) $rose(lockFault));
  c_retry:  cover property (@(posedge clk) disable iff (!resetn)
    state == clf_pkg::ST_RETRY ##1 state == clf_pkg::ST_RUN);
  c_report: cover property (@(posedge clk) disable iff (!resetn) state == clf_pkg::ST_REPORT);

endmodule // clf_lock_fault

/* clf_power_stage.sv */
// Behavioural motor power stage facing the lock fault handler
`timescale 1ns/1ns
module clf_power_stage (
  input  wire logic rotorLocked,
  input  wire logic gateTristate,
  input  wire logic lowSideBrake,
  input  wire logic highSideBrake,
  output logic      overLimit
);
  // A stalled rotor draws over-limit current only while the bridge still switches
  assign overLimit = rotorLocked & ~(gateTristate | lowSideBrake | highSideBrake);
endmodule // clf_power_stage

/* testbench.sv */
// Self-checking testbench for the current-limit lock fault handler
`timescale 1ns/1ns
module testbench;
  localparam int TICK = 10;

  logic        clk         = 1'b0;
  logic        resetn      = 1'b0;
  logic [2:0]  lockAction  = 3'h0;
  logic [3:0]  filterCode  = 4'h0;
  logic [15:0] retryWait   = 16'h0002;
  logic [3:0]  retryLimit  = 4'h1;
  logic        rotorLocked = 1'b0;
  logic        faultClear  = 1'b0;
  logic        overLimit;
  logic        faultIndicatorN;
  logic        gateTristate;
  logic        lowSideBrake;
  logic        highSideBrake;
  logic        lockFault;
  logic [3:0]  retryCount;
  int          miscompares = 0;
  int          nChecks     = 0;

  always #5 clk = ~clk;

  clf_power_stage stage (
    .rotorLocked   (rotorLocked),
    .gateTristate  (gateTristate),
    .lowSideBrake  (lowSideBrake),
    .highSideBrake (highSideBrake),
    .overLimit     (overLimit)
  );

  clf_lock_fault #(.TICK_CYCLES(TICK)) dut (
    .clk                        (clk),
    .resetn                     (resetn),
    .lockAction                 (lockAction),
    .lockCurrentLimitFilterTime (filterCode),
    .faultRetryWait             (retryWait),
    .retryCountLimit            (retryLimit),
    .overLimit                  (overLimit),
    .faultClear                 (faultClear),
    .faultIndicatorN            (faultIndicatorN),
    .gateTristate               (gateTristate),
    .lowSideBrake               (lowSideBrake),
    .highSideBrake              (highSideBrake),
    .lockFault                  (lockFault),
    .retryCount                 (retryCount)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expected);
    nChecks++;
    if (seen !== expected)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, expected, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_pin(input logic level, input int limit, output int used);
    used = 0;
    while (faultIndicatorN !== level && used < limit)
    begin
      @(negedge clk);
      used++;
    end
  endtask

  function automatic logic [15:0] gates();
    return {13'h0000, gateTristate, lowSideBrake, highSideBrake};
  endfunction

  function automatic logic [15:0] exp_gates(input int code);
    return (code % 3 == 0) ? 16'h0004 : (code % 3 == 1) ? 16'h0002 : 16'h0001;
  endfunction

  task automatic clear_fault();
    rotorLocked = 1'b0;
    cycles(1);
    faultClear = 1'b1;
    cycles(1);
    faultClear = 1'b0;
    cycles(1);
    check("pin after clear", 16'(faultIndicatorN), 16'h0001);
    check("fault after clear", 16'(lockFault), 16'h0000);
    check("gates after clear", gates(), 16'h0000);
    check("count after clear", 16'(retryCount), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic latch_modes();
    for (int c = 0; c < 3; c++)
    begin
      lockAction = 3'(c);
      rotorLocked = 1'b1;
      cycles(2);
      check("latched", 16'(lockFault), 16'h0001);
      check("pin latched", 16'(faultIndicatorN), 16'h0000);
      check("latch gates", gates(), exp_gates(c));
      cycles(8);
      check("latch holds", 16'(lockFault), 16'h0001);
      clear_fault();
    end
  endtask

  task automatic retry_modes();
    int used;
    for (int c = 3; c < 6; c++)
    begin
      lockAction = 3'(c);
      rotorLocked = 1'b1;
      cycles(2);
      check("pin retry", 16'(faultIndicatorN), 16'h0000);
      check("retry gates", gates(), exp_gates(c));
      check("retry count", 16'(retryCount), 16'h0001);
      check("not latched", 16'(lockFault), 16'h0000);
      wait_pin(1'b1, 4 * TICK, used);
      check("auto cleared", 16'(faultIndicatorN), 16'h0001);
      check("wait honoured", 16'(used >= 2 * TICK - 3), 16'h0001);
      cycles(2);
      check("latch past limit", 16'(lockFault), 16'h0001);
      check("final gates", gates(), exp_gates(c));
      check("count at limit", 16'(retryCount), 16'h0001);
      clear_fault();
    end
  endtask

  task automatic report_and_disable();
    lockAction = 3'h6;
    rotorLocked = 1'b1;
    cycles(12);
    check("report pin", 16'(faultIndicatorN), 16'h0000);
    check("report gates", gates(), 16'h0000);
    rotorLocked = 1'b0;
    cycles(2);
    check("report ends", 16'(faultIndicatorN), 16'h0001);
    lockAction = 3'h7;
    rotorLocked = 1'b1;
    cycles(50);
    check("disabled pin", 16'(faultIndicatorN), 16'h0001);
    check("disabled gates", gates(), 16'h0000);
    check("disabled fault", 16'(lockFault), 16'h0000);
    rotorLocked = 1'b0;
    cycles(1);
  endtask

  task automatic filter_times();
    int used;
    int t;
    lockAction = 3'h0;
    for (int code = 1; code < 4; code++)
    begin
      filterCode = 4'(code);
      t = int'(clf_pkg::FILTER_TICKS[code]) * TICK;
      rotorLocked = 1'b1;
      wait_pin(1'b0, t + 10, used);
      check("filter span", 16'(used >= t && used <= t + 3), 16'h0001);
      clear_fault();
    end
    filterCode = 4'h1;
    rotorLocked = 1'b1;
    cycles(TICK - 2);
    rotorLocked = 1'b0;
    cycles(1);
    rotorLocked = 1'b1;
    cycles(TICK - 2);
    check("glitch restarts", 16'(faultIndicatorN), 16'h0001);
    cycles(5);
    check("late detect", 16'(faultIndicatorN), 16'h0000);
    clear_fault();
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    results();
  end

  initial
  begin
    cycles(8);
    check("reset pin", 16'(faultIndicatorN), 16'h0001);
    check("reset gates", gates(), 16'h0000);
    resetn = 1'b1;
    cycles(1);
    latch_modes();
    retry_modes();
    report_and_disable();
    filter_times();
    results();
  end
endmodule // testbench
